// ---- bench/serial_mcu_model.sv ----
// microcontroller model driving the serial control port of the codec
`timescale 1ns/1ps

module serial_mcu_model (
   // clock
   input  wire logic core_clk,
   // serial control port
   output      logic serial_shift_clock,
   output      logic serial_data_in,
   output      logic serial_select_n
);
   // ==========================================
   // idle: deselected, shift clock parked low
   initial begin
      serial_shift_clock = 1'b0;
      serial_data_in     = 1'b0;
      serial_select_n    = 1'b1;
   end

   // three core cycles a phase, above the two-cycle sampling limit
   task automatic wait_phase();
      repeat (3) @(posedge core_clk);
   endtask

   // data set while the clock is low, stable across its rising edge
   task automatic shift_bit(input logic b);
      serial_data_in <= b;
      wait_phase();
      serial_shift_clock <= 1'b1;
      wait_phase();
      serial_shift_clock <= 1'b0;
   endtask

   task automatic send_bits(input logic [15:0] word, input int nbits);
      @(posedge core_clk);
      serial_select_n <= 1'b0;
      wait_phase();
      for (int i = nbits - 1; i >= 0; i--) begin
         shift_bit(word[i]);
      end
      wait_phase();
      serial_select_n <= 1'b1;
      // a released line must not keep showing the last bit
      serial_data_in <= ~serial_data_in;
      wait_phase();
   endtask

   // four address bits then one data byte
   task automatic write_reg(input logic [3:0] addr, input logic [7:0] data);
      send_bits({4'h0, addr, data}, 12);
   endtask

   // one bit short of a frame, meant to be refused
   task automatic write_short(input logic [10:0] bits);
      send_bits({5'h00, bits}, 11);
   endtask
endmodule // serial_mcu_model

// ---- bench/test_adpcm_codec_control_regs.sv ----
// self-checking testbench of the codec control register bank
`timescale 1ns/1ps

module test_adpcm_codec_control_regs
   import codec_ctrl_pkg::*;
;
   // ==========================================
   // one 8 kHz sampling period at 10 MHz
   localparam int SAMPLE_CYCLES = 1250;
   logic              core_clk;
   logic              reset;
   logic              powerdown_reset_pin;
   logic              serial_shift_clock;
   logic              serial_data_in;
   logic              serial_select_n;
   logic [7:0]        regs [4];
   logic              device_powerdown;
   logic [3:0]        adpcm_bits_per_sample;
   logic              tx_codec_reset;
   logic              rx_codec_reset;
   logic              tx_mute;
   logic              rx_mute;
   logic [4:0]        rx_pad_loss_db;
   logic              tx_pcm_on;
   logic              rx_pcm_on;
   logic signed [4:0] tx_gain_db;
   logic signed [4:0] rx_gain_db;
   logic              sidetone_on;
   logic signed [5:0] sidetone_gain_db;
   logic [8:0]        highpass_cutoff_factor;
   logic              highpass_in_path;
   int                mismatches;
   int                compares;
   int                seed;
   logic [7:0]        exp_regs [4];
   logic              exp_pin_low;

   // clock
   initial core_clk = 1'b0;
   always #50 core_clk = ~core_clk;

   adpcm_codec_control_regs #(.ADDR_BITS(4)) uut (
      .core_clk(core_clk), .reset(reset), .serial_shift_clock(serial_shift_clock),
      .serial_data_in(serial_data_in), .serial_select_n(serial_select_n),
      .powerdown_reset_pin(powerdown_reset_pin), .basic_operating_mode(regs[0]),
      .adpcm_operating_mode(regs[1]), .pcm_path_and_gain(regs[2]), .sidetone_and_highpass(regs[3]),
      .device_powerdown(device_powerdown), .adpcm_bits_per_sample(adpcm_bits_per_sample),
      .tx_codec_reset(tx_codec_reset), .rx_codec_reset(rx_codec_reset), .tx_mute(tx_mute),
      .rx_mute(rx_mute), .rx_pad_loss_db(rx_pad_loss_db), .tx_pcm_on(tx_pcm_on), .rx_pcm_on(rx_pcm_on),
      .tx_gain_db(tx_gain_db), .rx_gain_db(rx_gain_db), .sidetone_on(sidetone_on),
      .sidetone_gain_db(sidetone_gain_db), .highpass_cutoff_factor(highpass_cutoff_factor),
      .highpass_in_path(highpass_in_path));

   serial_mcu_model mcu (
      .core_clk(core_clk), .serial_shift_clock(serial_shift_clock),
      .serial_data_in(serial_data_in), .serial_select_n(serial_select_n));

   // ==========================================
   task automatic check(input logic [8:0] seen, input logic [8:0] expd);
      compares++;
      if (seen !== expd) begin
         mismatches++;
         $display("FAIL at %0t: seen %h expected %h", $time, seen, expd);
      end
   endtask

   // decoded outputs worked out from the expected register image
   task automatic check_all();
      int w;
      int st;
      case (exp_regs[1][7:6])
         2'h0: w = 4;
         2'h1: w = 8;
         2'h2: w = 3;
         default: w = 2;
      endcase
      st = (exp_regs[3][7:5] == 3'h0) ? 0 : 2 * int'(exp_regs[3][7:5]) - 23;
      for (int r = 0; r < 4; r++) check(9'(regs[r]), 9'(exp_regs[r]));
      check(9'(device_powerdown), 9'(exp_regs[0][5] | exp_pin_low));
      check(9'(adpcm_bits_per_sample), 9'(w));
      check(9'(tx_codec_reset), 9'(exp_regs[1][5]));
      check(9'(rx_codec_reset), 9'(exp_regs[1][4]));
      check(9'(tx_mute), 9'(exp_regs[1][3]));
      check(9'(rx_mute), 9'(exp_regs[1][2]));
      check(9'(rx_pad_loss_db), exp_regs[1][0] ? 9'h00c : 9'h000);
      check(9'(tx_pcm_on), 9'(!exp_regs[2][7]));
      check(9'(rx_pcm_on), 9'(!exp_regs[2][3]));
      check(9'(tx_gain_db), 9'(2 * int'(exp_regs[2][6:4]) - 6));
      check(9'(rx_gain_db), 9'(2 * int'(exp_regs[2][2:0]) - 6));
      check(9'(sidetone_on), 9'(exp_regs[3][7:5] != 3'h0));
      check(9'(sidetone_gain_db), 9'(st));
      check(highpass_cutoff_factor, exp_regs[3][1] ? 9'h0c8 : 9'h113);
      check(9'(highpass_in_path), 9'(!exp_regs[3][0]));
   endtask

   function automatic logic [7:0] legal(input logic [1:0] a, input logic [7:0] d);
      case (a)
         2'h0: return d & 8'h20;
         2'h1: return d & 8'hcd;
         2'h3: return d & 8'he3;
         default: return d;
      endcase
   endfunction

   // only whole frames to mapped registers with the pin high commit
   task automatic wr(input logic [3:0] addr, input logic [7:0] data);
      mcu.write_reg(addr, data);
      if (addr < 4'h4 && !exp_pin_low) exp_regs[addr[1:0]] = data;
      repeat (6) @(posedge core_clk);
      #1;
      check_all();
   endtask

   task automatic give_verdict();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // ==========================================
   // main sequence
   initial begin
      reset = 1'b1;
      powerdown_reset_pin = 1'b1;
      mismatches = 0;
      compares = 0;
      seed = 13431;
      exp_pin_low = 1'b0;
      exp_regs = '{INIT_BASIC_OPERATING_MODE, INIT_ADPCM_OPERATING_MODE,
                   INIT_PCM_PATH_AND_GAIN, INIT_SIDETONE_AND_HIGHPASS};
      repeat (4) @(posedge core_clk);
      reset <= 1'b0;
      repeat (3) @(posedge core_clk);
      #1;
      check_all();
      // every width, gain, side-tone and filter code, flags toggling
      for (int c = 0; c < 8; c++) begin
         logic [2:0] k;
         k = 3'(c);
         wr(4'h0, {2'h0, k[0], 5'h00});
         wr(4'h1, legal(2'h1, {k[1:0], 2'h0, k[1:0], 1'b0, k[0]}));
         wr(4'h2, {k[0], k, ~k[0], ~k});
         wr(4'h3, {k, 3'h0, k[1:0]});
      end
      wr(4'h1, 8'h30);
      repeat (SAMPLE_CYCLES) @(posedge core_clk);
      wr(4'h1, 8'h00);
      // unmapped addresses and a short frame leave all registers alone
      wr(4'h4, 8'hff);
      wr(4'hf, 8'h5a);
      mcu.write_short(11'h2ff);
      repeat (6) @(posedge core_clk);
      #1;
      check_all();
      // back-to-back random frames, unmapped addresses included
      for (int n = 0; n < 30; n++) begin
         logic [31:0] rnd;
         rnd = $random(seed);
         wr(rnd[3:0], legal(rnd[1:0], rnd[11:4]));
      end
      // mid-run reset brings every register back to its initial value
      @(posedge core_clk);
      reset <= 1'b1;
      repeat (2) @(posedge core_clk);
      reset <= 1'b0;
      repeat (3) @(posedge core_clk);
      #1;
      exp_regs = '{INIT_BASIC_OPERATING_MODE, INIT_ADPCM_OPERATING_MODE,
                   INIT_PCM_PATH_AND_GAIN, INIT_SIDETONE_AND_HIGHPASS};
      check_all();
      // pin low loads initial values and blocks writes
      @(posedge core_clk);
      powerdown_reset_pin <= 1'b0;
      repeat (5) @(posedge core_clk);
      #1;
      exp_pin_low = 1'b1;
      exp_regs = '{INIT_BASIC_OPERATING_MODE, INIT_ADPCM_OPERATING_MODE,
                   INIT_PCM_PATH_AND_GAIN, INIT_SIDETONE_AND_HIGHPASS};
      check_all();
      wr(4'h2, 8'h77);
      @(posedge core_clk);
      powerdown_reset_pin <= 1'b1;
      repeat (5) @(posedge core_clk);
      #1;
      exp_pin_low = 1'b0;
      check_all();
      give_verdict();
   end

   // about three times the expected run; a hang counts as a mismatch
   initial begin
      repeat (20000) @(posedge core_clk);
      mismatches++;
      give_verdict();
   end
endmodule // test_adpcm_codec_control_regs

// ---- hw/adpcm_codec_control_regs.sv ----
// control register bank of the adpcm codec, written over the serial control port
`timescale 1ns/1ps

module adpcm_codec_control_regs
   import codec_ctrl_pkg::*;
#(
   parameter int ADDR_BITS = ADDR_BITS_DEFAULT
) (
   // clock and reset
   input  wire logic               core_clk,
   input  wire logic               reset,
   // serial control port pins (asynchronous)
   input  wire logic               serial_shift_clock,
   input  wire logic               serial_data_in,
   input  wire logic               serial_select_n,
   // power-down/reset pin, low means power-down and register reset
   input  wire logic               powerdown_reset_pin,
   // register contents
   output      logic [7:0]         basic_operating_mode,
   output      logic [7:0]         adpcm_operating_mode,
   output      logic [7:0]         pcm_path_and_gain,
   output      logic [7:0]         sidetone_and_highpass,
   // power control
   output      logic               device_powerdown,
   // adpcm controls
   output      logic [3:0]         adpcm_bits_per_sample,
   output      logic               tx_codec_reset,
   output      logic               rx_codec_reset,
   output      logic               tx_mute,
   output      logic               rx_mute,
   output      logic [4:0]         rx_pad_loss_db,
   // pcm path controls
   output      logic               tx_pcm_on,
   output      logic               rx_pcm_on,
   output      logic signed [4:0]  tx_gain_db,
   output      logic signed [4:0]  rx_gain_db,
   // side-tone and high-pass controls
   output      logic               sidetone_on,
   output      logic signed [5:0]  sidetone_gain_db,
   output      logic [8:0]         highpass_cutoff_factor,
   output      logic               highpass_in_path
);

   // ==========================================================
   // elaboration check
   localparam int FRAME_BITS = ADDR_BITS + DATA_BITS;

   generate
      if (ADDR_BITS < 2 || ADDR_BITS > 8) begin : g_bad_addr
         $error("ADDR_BITS must lie between 2 and 8");
      end
   endgenerate

   // ==========================================================
   // state
   typedef struct packed {
      logic [NUM_REGS-1:0][7:0] regs;
      logic [FRAME_BITS-1:0]    shift;
      logic [4:0]               count;
      logic                     sclk_prev;
      logic                     sel_n_prev;
      logic                     powerdown;
      logic [3:0]               bits_per_sample;
      logic signed [4:0]        tx_gain;
      logic signed [4:0]        rx_gain;
      logic                     st_on;
      logic signed [5:0]        st_gain;
      logic [8:0]               hpf_factor;
   } ctrl_state_t;

   ctrl_state_t state;
   ctrl_state_t next_state;

   // ==========================================================
   // pin synchronisation
   logic [3:0] pins_synced;
   logic       sclk_s;
   logic       din_s;
   logic       sel_n_s;
   logic       pdn_s;

   pin_synchronizer #(
      .WIDTH      (4),
      .RESET_BITS (4'hc)
   ) u_sync (
      .core_clk (core_clk),
      .reset    (reset),
      .pins     ({powerdown_reset_pin, serial_select_n, serial_data_in, serial_shift_clock}),
      .synced   (pins_synced)
   );

   assign sclk_s  = pins_synced[0];
   assign din_s   = pins_synced[1];
   assign sel_n_s = pins_synced[2];
   assign pdn_s   = pins_synced[3];

   // ==========================================================
   // serial frame events
   logic                 sclk_rise;
   logic                 frame_start;
   logic                 frame_end;
   logic                 commit;
   logic [ADDR_BITS-1:0] frame_addr;
   logic [7:0]           frame_data;

   // edges are taken from the synchronised copies only
   assign sclk_rise   = sclk_s && !state.sclk_prev && !sel_n_s;
   assign frame_start = !sel_n_s && state.sel_n_prev;
   assign frame_end   = sel_n_s && !state.sel_n_prev;
   assign frame_addr  = state.shift[FRAME_BITS-1:DATA_BITS];
   assign frame_data  = state.shift[DATA_BITS-1:0];
   // commit only a whole frame to a mapped address
   // compared as int so a two-bit address field still sees all four registers
   assign commit      = frame_end && pdn_s && (state.count == 5'(FRAME_BITS))
                        && (int'(frame_addr) < NUM_REGS);

   // ==========================================================
   // next-state logic
   always_comb begin
      logic [7:0] r0;
      logic [7:0] r1;
      logic [7:0] r2;
      logic [7:0] r3;
      r0                   = 8'h00;
      r1                   = 8'h00;
      r2                   = 8'h00;
      r3                   = 8'h00;
      next_state           = state;
      next_state.sclk_prev = sclk_s;
      next_state.sel_n_prev = sel_n_s;

      // shift address then data, msb first
      if (frame_start) begin
         next_state.count = 5'h00;
      end else if (sclk_rise) begin
         next_state.shift = {state.shift[FRAME_BITS-2:0], din_s};
         // saturates so an overlong frame never reads as complete
         if (state.count != 5'h1f) begin
            next_state.count = state.count + 5'h01;
         end
      end

      // write the addressed register at frame end
      if (commit) begin
         next_state.regs[frame_addr[1:0]] = frame_data;
      end

      // pin low restores initial values and drops any frame
      if (!pdn_s) begin
         next_state.regs[OFS_BASIC_OPERATING_MODE]  = INIT_BASIC_OPERATING_MODE;
         next_state.regs[OFS_ADPCM_OPERATING_MODE]  = INIT_ADPCM_OPERATING_MODE;
         next_state.regs[OFS_PCM_PATH_AND_GAIN]     = INIT_PCM_PATH_AND_GAIN;
         next_state.regs[OFS_SIDETONE_AND_HIGHPASS] = INIT_SIDETONE_AND_HIGHPASS;
         next_state.count = 5'h00;
      end

      r0 = next_state.regs[OFS_BASIC_OPERATING_MODE];
      r1 = next_state.regs[OFS_ADPCM_OPERATING_MODE];
      r2 = next_state.regs[OFS_PCM_PATH_AND_GAIN];
      r3 = next_state.regs[OFS_SIDETONE_AND_HIGHPASS];

      next_state.powerdown = r0[GLOBAL_POWERDOWN_BIT] || !pdn_s;

      // width code to bits per sample
      case (r1[WIDTH_SELECT_HIGH:WIDTH_SELECT_LOW])
         WIDTH_CODE_4: next_state.bits_per_sample = 4'h4;
         WIDTH_CODE_8: next_state.bits_per_sample = 4'h8;
         WIDTH_CODE_3: next_state.bits_per_sample = 4'h3;
         WIDTH_CODE_2: next_state.bits_per_sample = 4'h2;
         default:      next_state.bits_per_sample = 4'h4;
      endcase

      // two dB per code step, 011 is unity
      next_state.tx_gain = $signed({1'b0, r2[TX_GAIN_CODE_MSB -: 3], 1'b0}) - PATH_GAIN_OFFSET_DB;
      next_state.rx_gain = $signed({1'b0, r2[RX_GAIN_CODE_MSB -: 3], 1'b0}) - PATH_GAIN_OFFSET_DB;

      if (r3[SIDETONE_GAIN_CODE_MSB -: 3] == SIDETONE_OFF_CODE) begin
         next_state.st_on   = 1'b0;
         next_state.st_gain = 6'sh00;
      end else begin
         next_state.st_on   = 1'b1;
         next_state.st_gain = $signed({2'b00, r3[SIDETONE_GAIN_CODE_MSB -: 3], 1'b0}) - SIDETONE_GAIN_OFFSET_DB;
      end

      // cut-off factor in parts per ten thousand of fs
      next_state.hpf_factor = r3[HIGHPASS_CUTOFF_SELECT] ? HPF_FACTOR_NARROW : HPF_FACTOR_WIDE;
   end

   // ==========================================================
   // state register
   always_ff @(posedge core_clk) begin
      if (reset) begin
         state.regs[OFS_BASIC_OPERATING_MODE]  <= INIT_BASIC_OPERATING_MODE;
         state.regs[OFS_ADPCM_OPERATING_MODE]  <= INIT_ADPCM_OPERATING_MODE;
         state.regs[OFS_PCM_PATH_AND_GAIN]     <= INIT_PCM_PATH_AND_GAIN;
         state.regs[OFS_SIDETONE_AND_HIGHPASS] <= INIT_SIDETONE_AND_HIGHPASS;
         state.shift           <= '0;
         state.count           <= 5'h00;
         state.sclk_prev       <= 1'b0;
         state.sel_n_prev      <= 1'b1;
         state.powerdown       <= 1'b0;
         state.bits_per_sample <= 4'h4;
         state.tx_gain         <= 5'sh00;
         state.rx_gain         <= 5'sh00;
         state.st_on           <= 1'b0;
         state.st_gain         <= 6'sh00;
         state.hpf_factor      <= HPF_FACTOR_WIDE;
      end else begin
         state <= next_state;
      end
   end

   // ==========================================================
   // outputs from flops; pad loss, pcm on and high-pass in-path decoded by logic after the flops
   assign basic_operating_mode  = state.regs[OFS_BASIC_OPERATING_MODE];
   assign adpcm_operating_mode  = state.regs[OFS_ADPCM_OPERATING_MODE];
   assign pcm_path_and_gain     = state.regs[OFS_PCM_PATH_AND_GAIN];
   assign sidetone_and_highpass = state.regs[OFS_SIDETONE_AND_HIGHPASS];

   assign device_powerdown      = state.powerdown;
   assign adpcm_bits_per_sample = state.bits_per_sample;

   // codec reset levels held as long as the bits stay set
   assign tx_codec_reset = adpcm_operating_mode[TX_CODEC_RESET_BIT];
   assign rx_codec_reset = adpcm_operating_mode[RX_CODEC_RESET_BIT];

   assign tx_mute = adpcm_operating_mode[TX_MUTE_BIT];
   assign rx_mute = adpcm_operating_mode[RX_MUTE_BIT];

   assign rx_pad_loss_db = adpcm_operating_mode[RX_PAD_BIT] ? RX_PAD_LOSS_DB : 5'h00;

   assign tx_pcm_on = !pcm_path_and_gain[TX_PCM_OFF_BIT];
   assign rx_pcm_on = !pcm_path_and_gain[RX_PCM_OFF_BIT];

   assign tx_gain_db             = state.tx_gain;
   assign rx_gain_db             = state.rx_gain;
   assign sidetone_on            = state.st_on;
   assign sidetone_gain_db       = state.st_gain;
   assign highpass_cutoff_factor = state.hpf_factor;

   assign highpass_in_path = !sidetone_and_highpass[HIGHPASS_BYPASS];

   // ==========================================================
   // assertions
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (reset);

   chk_global_powerdown: assert property (
      (pdn_s && !commit && basic_operating_mode[GLOBAL_POWERDOWN_BIT]) |=> device_powerdown)
      else $error("global power-down bit set but device not powered down");

   chk_powerdown_or: assert property (
      (pdn_s && !commit && !basic_operating_mode[GLOBAL_POWERDOWN_BIT]) ##1 pdn_s |-> !device_powerdown)
      else $error("power-down active with bit clear and pin high");

   chk_width_decode: assert property (
      adpcm_bits_per_sample == ((adpcm_operating_mode[7:6] == 2'b00) ? 4'h4 :
                                (adpcm_operating_mode[7:6] == 2'b01) ? 4'h8 :
                                (adpcm_operating_mode[7:6] == 2'b10) ? 4'h3 : 4'h2))
      else $error("bits per sample does not match width code");

   chk_codec_reset_write: assert property (
      (commit && frame_addr == ADDR_BITS'(1)) |=> (tx_codec_reset == $past(frame_data[5]))
                                               && (rx_codec_reset == $past(frame_data[4])))
      else $error("codec reset level does not follow written byte");

   chk_mute_pad: assert property (
      (commit && frame_addr == ADDR_BITS'(1)) |=> (tx_mute == $past(frame_data[3]))
         && (rx_mute == $past(frame_data[2])) && (rx_pad_loss_db == ($past(frame_data[0]) ? 5'd12 : 5'd0)))
      else $error("mute or pad does not follow written byte");

   chk_path_enable: assert property (
      (commit && frame_addr == ADDR_BITS'(2)) |=> (tx_pcm_on == !$past(frame_data[7]))
                                               && (rx_pcm_on == !$past(frame_data[3])))
      else $error("pcm path on/off does not follow written byte");

   chk_gain_map: assert property (
      (int'(tx_gain_db) == 2 * int'(pcm_path_and_gain[6:4]) - 6)
      && (int'(rx_gain_db) == 2 * int'(pcm_path_and_gain[2:0]) - 6))
      else $error("path gain does not match gain code");

   chk_sidetone_map: assert property (
      (sidetone_and_highpass[7:5] == 3'h0) ? !sidetone_on
      : (sidetone_on && int'(sidetone_gain_db) == 2 * int'(sidetone_and_highpass[7:5]) - 23))
      else $error("side-tone gain does not match code");

   chk_highpass_sel: assert property (
      highpass_cutoff_factor == (sidetone_and_highpass[1] ? 9'd200 : 9'd275))
      else $error("high-pass cut-off factor wrong");

   chk_pin_restores: assert property (
      !pdn_s |=> device_powerdown && basic_operating_mode == 8'h00 && adpcm_operating_mode == 8'h00
                 && pcm_path_and_gain == 8'h33 && sidetone_and_highpass == 8'h00)
      else $error("pin low did not restore initial values");

   chk_commit_write: assert property (
      commit |=> state.regs[$past(frame_addr[1:0])] == $past(frame_data))
      else $error("completed frame not written to addressed register");

   chk_pin_latency: assert property (
      !powerdown_reset_pin ##1 !powerdown_reset_pin ##1 !powerdown_reset_pin |=> device_powerdown)
      else $error("pin low not seen after synchroniser latency");

   chk_highpass_bypass: assert property (
      (commit && frame_addr == ADDR_BITS'(3)) |=> (highpass_in_path == !$past(frame_data[0])))
      else $error("high-pass bypass does not follow written byte");

   chk_bad_frame_ignored: assert property (
      (frame_end && pdn_s && (state.count != 5'(FRAME_BITS) || frame_addr > ADDR_BITS'(3))) |=> $stable(state.regs))
      else $error("short or unmapped frame changed a register");

endmodule // adpcm_codec_control_regs

// ---- hw/codec_ctrl_pkg.sv ----
// package: register map, field positions, reset values and codes of the codec control bank
package codec_ctrl_pkg;

   // ==========================================================
   // register indices (serial address field)
   localparam logic [1:0] OFS_BASIC_OPERATING_MODE  = 2'h0;
   localparam logic [1:0] OFS_ADPCM_OPERATING_MODE  = 2'h1;
   localparam logic [1:0] OFS_PCM_PATH_AND_GAIN     = 2'h2;
   localparam logic [1:0] OFS_SIDETONE_AND_HIGHPASS = 2'h3;
   localparam int         NUM_REGS                  = 4;
   localparam int         DATA_BITS                 = 8;

   // ==========================================================
   // initial values loaded by reset and by the power-down/reset pin
   localparam logic [7:0] INIT_BASIC_OPERATING_MODE  = 8'h00;
   localparam logic [7:0] INIT_ADPCM_OPERATING_MODE  = 8'h00;
   localparam logic [7:0] INIT_PCM_PATH_AND_GAIN     = 8'h33;
   localparam logic [7:0] INIT_SIDETONE_AND_HIGHPASS = 8'h00;

   // ==========================================================
   // basic operating mode fields
   localparam int GLOBAL_POWERDOWN_BIT = 5;

   // adpcm operating mode fields
   localparam int WIDTH_SELECT_HIGH    = 7;
   localparam int WIDTH_SELECT_LOW     = 6;
   localparam int TX_CODEC_RESET_BIT   = 5;
   localparam int RX_CODEC_RESET_BIT   = 4;
   localparam int TX_MUTE_BIT          = 3;
   localparam int RX_MUTE_BIT          = 2;
   localparam int RX_PAD_BIT           = 0;

   // pcm path and gain fields
   localparam int TX_PCM_OFF_BIT       = 7;
   localparam int TX_GAIN_CODE_MSB     = 6;
   localparam int RX_PCM_OFF_BIT       = 3;
   localparam int RX_GAIN_CODE_MSB     = 2;

   // side-tone and high-pass fields
   localparam int SIDETONE_GAIN_CODE_MSB = 7;
   localparam int HIGHPASS_CUTOFF_SELECT = 1;
   localparam int HIGHPASS_BYPASS        = 0;

   // ==========================================================
   // width select codes and resulting bits per sample
   localparam logic [1:0] WIDTH_CODE_4 = 2'h0;
   localparam logic [1:0] WIDTH_CODE_8 = 2'h1;
   localparam logic [1:0] WIDTH_CODE_3 = 2'h2;
   localparam logic [1:0] WIDTH_CODE_2 = 2'h3;

   // ==========================================================
   // gain mapping: db = 2*code - offset
   localparam logic signed [4:0] PATH_GAIN_OFFSET_DB     = 5'sh06;
   localparam logic signed [5:0] SIDETONE_GAIN_OFFSET_DB = 6'sh17;
   localparam logic [2:0]        SIDETONE_OFF_CODE       = 3'h0;
   localparam logic [4:0]        RX_PAD_LOSS_DB          = 5'h0c;

   // high-pass cut-off as parts per ten thousand of the sampling rate
   localparam logic [8:0] HPF_FACTOR_WIDE   = 9'h113;
   localparam logic [8:0] HPF_FACTOR_NARROW = 9'h0c8;

   // ==========================================================
   // serial frame defaults
   localparam int ADDR_BITS_DEFAULT = 4;

endpackage

// ---- hw/pin_synchronizer.sv ----
// two-flop synchroniser for a group of asynchronous input pins
`timescale 1ns/1ps

module pin_synchronizer
   import codec_ctrl_pkg::*;
#(
   parameter int                 WIDTH      = 4,
   parameter logic [WIDTH-1:0]   RESET_BITS = '0
) (
   // clock and reset
   input  wire logic              core_clk,
   input  wire logic              reset,
   // pins in, synchronised copy out
   input  wire logic [WIDTH-1:0]  pins,
   output      logic [WIDTH-1:0]  synced
);

   typedef struct packed {
      logic [WIDTH-1:0] stage1;
      logic [WIDTH-1:0] stage2;
   } sync_state_t;

   sync_state_t state;
   sync_state_t next_state;

   // ==========================================================
   // stage1 feeds only stage2; nothing else may look at it
   always_comb begin
      next_state.stage1 = pins;
      next_state.stage2 = state.stage1;
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         state.stage1 <= RESET_BITS;
         state.stage2 <= RESET_BITS;
      end else begin
         state <= next_state;
      end
   end

   assign synced = state.stage2;

endmodule // pin_synchronizer
